/* rtl/ext_tick_sync.sv */
`timescale 1ns/1ps
module ext_tick_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // External oscillator pin
  input wire logic ext_osc,
  // One tick per eight external rising edges
  output logic ext_tick
);

  logic [2:0] sync_r;
  logic level_r;
  logic [2:0] div_r;
  logic tick_r;
  wire logic stable = (sync_r[2] == sync_r[1]);
  wire logic rise = stable && sync_r[1] && !level_r;

  // ------------------------------------------------------------
  // Synchroniser and divider
  // ------------------------------------------------------------
  // Each source level must hold for two pclk samples or edges are missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], ext_osc};
      if (stable) begin
        level_r <= sync_r[1];
      end
      if (rise) begin
        div_r <= (div_r == split_timer_pkg::ext_div_last) ? 3'h0 : div_r + 3'h1;
      end
      tick_r <= rise && (div_r == split_timer_pkg::ext_div_last);
    end
  end

  assign ext_tick = tick_r;

endmodule // ext_tick_sync

/* rtl/split_reload_timer.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module split_reload_timer (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External oscillator
  input wire logic ext_osc,
  // Interrupts
  output logic timer_irq,
  output logic irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] rld_lo_r;
  logic [7:0] rld_hi_r;
  logic [7:0] cnt_lo_r;
  logic [7:0] cnt_hi_r;
  logic [2:0] clk_ctl_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [3:0] pre12_r;
  logic [31:0] prdata_r;
  logic ext_tick;

  ext_tick_sync u_ext (
    .pclk(pclk),
    .presetn(presetn),
    .ext_osc(ext_osc),
    .ext_tick(ext_tick)
  );

  function automatic logic pick_tick(input logic sys_sel, input logic ext_sel,
                                     input logic t12, input logic tx);
    pick_tick = sys_sel ? 1'b1 : (ext_sel ? tx : t12);
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pstrb[0];
  wire logic hit_ctrl = (paddr == split_timer_pkg::ctrl_off);
  wire logic hit_rll = (paddr == split_timer_pkg::rld_lo_off);
  wire logic hit_rlh = (paddr == split_timer_pkg::rld_hi_off);
  wire logic hit_cl = (paddr == split_timer_pkg::cnt_lo_off);
  wire logic hit_ch = (paddr == split_timer_pkg::cnt_hi_off);
  wire logic hit_ck = (paddr == split_timer_pkg::clk_ctl_off);
  wire logic hit_st = (paddr == split_timer_pkg::irq_stat_off);
  wire logic hit_mk = (paddr == split_timer_pkg::irq_mask_off);
  wire logic mapped = hit_ctrl || hit_rll || hit_rlh || hit_cl || hit_ch
                      || hit_ck || hit_st || hit_mk;
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) rd_mux = {24'h0, ctrl_r & split_timer_pkg::ctrl_wmask};
    else if (hit_rll) rd_mux = {24'h0, rld_lo_r};
    else if (hit_rlh) rd_mux = {24'h0, rld_hi_r};
    else if (hit_cl) rd_mux = {24'h0, cnt_lo_r};
    else if (hit_ch) rd_mux = {24'h0, cnt_hi_r};
    else if (hit_ck) rd_mux = {29'h0, clk_ctl_r};
    else if (hit_st) rd_mux = {30'h0, irq_stat_r};
    else if (hit_mk) rd_mux = {30'h0, irq_mask_r};
    else rd_mux = 32'h0;
  end

  // ------------------------------------------------------------
  // Tick selection
  // ------------------------------------------------------------
  wire logic tick12 = (pre12_r == split_timer_pkg::sys_div_last);
  wire logic split = ctrl_r[split_timer_pkg::split_bit];
  wire logic run = ctrl_r[split_timer_pkg::run_bit];
  wire logic xsel = ctrl_r[split_timer_pkg::ext_sel_bit];
  split_timer_pkg::tick_s tk;
  // One driver for the whole struct
  assign tk = {
    pick_tick(clk_ctl_r[split_timer_pkg::high_clk_bit], xsel, tick12, ext_tick),
    pick_tick(clk_ctl_r[split_timer_pkg::low_clk_bit], xsel, tick12, ext_tick)
  };

  // 16-bit mode uses the high byte's source and run enable
  wire logic inc_lo = split ? tk.low : (run && tk.high);
  wire logic inc_hi_split = run && tk.high;
  wire logic lo_ovf = inc_lo && (cnt_lo_r == split_timer_pkg::byte_max);
  wire logic hi_ovf = split ? (inc_hi_split && (cnt_hi_r == split_timer_pkg::byte_max))
                            : lo_ovf && (cnt_hi_r == split_timer_pkg::byte_max);
  wire logic inc_hi = split ? inc_hi_split : lo_ovf;

  logic [7:0] lo_nxt;
  logic [7:0] hi_nxt;
  always_comb begin
    lo_nxt = cnt_lo_r;
    hi_nxt = cnt_hi_r;
    if (split) begin
      if (lo_ovf) lo_nxt = rld_lo_r;
      else if (inc_lo) lo_nxt = cnt_lo_r + 8'h01;
      if (hi_ovf) hi_nxt = rld_hi_r;
      else if (inc_hi) hi_nxt = cnt_hi_r + 8'h01;
    end else if (hi_ovf) begin
      lo_nxt = rld_lo_r;
      hi_nxt = rld_hi_r;
    end else begin
      if (inc_lo) lo_nxt = cnt_lo_r + 8'h01;
      if (inc_hi) hi_nxt = cnt_hi_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Flags: hardware set wins over software clear
  // ------------------------------------------------------------
  wire logic ctl_wr = wr && hit_ctrl;
  wire logic hf_cur = ctrl_r[split_timer_pkg::high_ovf_bit];
  wire logic lf_cur = ctrl_r[split_timer_pkg::low_ovf_bit];
  wire logic hf_nxt = hi_ovf ? 1'b1
                      : (ctl_wr ? pwdata[split_timer_pkg::high_ovf_bit] : hf_cur);
  wire logic lf_nxt = lo_ovf ? 1'b1
                      : (ctl_wr ? pwdata[split_timer_pkg::low_ovf_bit] : lf_cur);
  logic [7:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctl_wr ? (pwdata[7:0] & split_timer_pkg::ctrl_wmask) : ctrl_r;
    ctrl_nxt[split_timer_pkg::high_ovf_bit] = hf_nxt;
    ctrl_nxt[split_timer_pkg::low_ovf_bit] = lf_nxt;
  end

  // Sticky event status, write one to clear
  wire logic [1:0] ev = {lo_ovf, hi_ovf};
  wire logic [1:0] st_clr = (wr && hit_st) ? pwdata[1:0] : 2'h0;
  wire logic [1:0] st_nxt = ev | (irq_stat_r & ~st_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= split_timer_pkg::ctrl_rst;
      rld_lo_r <= split_timer_pkg::byte_rst;
      rld_hi_r <= split_timer_pkg::byte_rst;
      cnt_lo_r <= split_timer_pkg::byte_rst;
      cnt_hi_r <= split_timer_pkg::byte_rst;
      clk_ctl_r <= split_timer_pkg::clk_ctl_rst;
      irq_stat_r <= split_timer_pkg::irq_rst;
      irq_mask_r <= split_timer_pkg::irq_rst;
      pre12_r <= 4'h0;
      prdata_r <= 32'h0;
    end else begin
      pre12_r <= tick12 ? 4'h0 : pre12_r + 4'h1;
      ctrl_r <= ctrl_nxt;
      irq_stat_r <= st_nxt;
      if (wr && hit_rll) rld_lo_r <= pwdata[7:0];
      if (wr && hit_rlh) rld_hi_r <= pwdata[7:0];
      // Software count writes take priority over counting
      cnt_lo_r <= (wr && hit_cl) ? pwdata[7:0] : lo_nxt;
      cnt_hi_r <= (wr && hit_ch) ? pwdata[7:0] : hi_nxt;
      if (wr && hit_ck) clk_ctl_r <= pwdata[2:0];
      if (wr && hit_mk) irq_mask_r <= pwdata[1:0];
      prdata_r <= (psel && !penable && !pwrite) ? rd_mux : prdata_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  wire logic tie = clk_ctl_r[split_timer_pkg::tmr_irq_en_bit];
  assign timer_irq = tie && (hf_cur
                     || (lf_cur && ctrl_r[split_timer_pkg::low_irq_en_bit]));
  assign irq = |(irq_stat_r & irq_mask_r);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;

endmodule // split_reload_timer

/* rtl/split_timer_pkg.sv */
// Functional notes
// - Split mode set: two separate 8-bit auto-reload counters, high and low byte.
// - Split mode: each byte reloads from its own reload register on overflow.
// - Split mode: run enable gates high byte only; low byte always counts.
// - Each byte clocked from system clock, clock/12, or external clock/8.
// - Byte select one picks system clock; else external select picks /12 or ext/8.
// - External /8 clock synchronized; source must not exceed system clock.
// - High and low overflow flags set on their byte rolling FF to 00.
// - Split mode with timer interrupt enabled: interrupt on every high overflow.
// - Low byte interrupt enable adds interrupts on each low byte overflow.
// - Hardware never clears overflow flags; software clears them by writing.
// - Split clear: one 16-bit counter, reloads on FFFF rollover, sets high flag.
// - 16-bit mode: low enable adds interrupt whenever lower eight bits roll over.
package split_timer_pkg;

  // ------------------------------------------------------------
  // Register word index and byte addresses
  // ------------------------------------------------------------
  localparam logic [11:0] ctrl_idx = 12'h091;
  localparam logic [11:0] ctrl_off = 12'h244;
  localparam logic [11:0] rld_lo_off = 12'h248;
  localparam logic [11:0] rld_hi_off = 12'h24C;
  localparam logic [11:0] cnt_lo_off = 12'h250;
  localparam logic [11:0] cnt_hi_off = 12'h254;
  localparam logic [11:0] clk_ctl_off = 12'h258;
  localparam logic [11:0] irq_stat_off = 12'h25C;
  localparam logic [11:0] irq_mask_off = 12'h260;

  // ------------------------------------------------------------
  // Control fields and reset values
  // ------------------------------------------------------------
  localparam int high_ovf_bit = 7;
  localparam int low_ovf_bit = 6;
  localparam int low_irq_en_bit = 5;
  localparam int split_bit = 3;
  localparam int run_bit = 2;
  localparam int ext_sel_bit = 0;
  localparam logic [7:0] ctrl_wmask = 8'hED;
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] byte_rst = 8'h00;
  localparam logic [7:0] byte_max = 8'hFF;

  // Clock control: bit0 low byte sys_clock, bit1 high byte sys_clock, bit2 timer irq enable
  localparam int low_clk_bit = 0;
  localparam int high_clk_bit = 1;
  localparam int tmr_irq_en_bit = 2;
  localparam logic [2:0] clk_ctl_rst = 3'h0;

  // Interrupt status/mask: bit0 high overflow, bit1 low overflow
  localparam logic [1:0] irq_rst = 2'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int sys_div = 12;
  localparam int ext_div = 8;
  localparam logic [3:0] sys_div_last = 4'(sys_div - 1);
  localparam logic [2:0] ext_div_last = 3'(ext_div - 1);

  typedef struct packed {
    logic high;
    logic low;
  } tick_s;

endpackage

/* sim/split_reload_timer_assertions.sv */
`timescale 1ns/1ps
module split_reload_timer_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and interrupts
  input wire logic ext_osc,
  input wire logic timer_irq,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Map is one aligned run of words
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = paddr >= split_timer_pkg::ctrl_off && paddr <= split_timer_pkg::irq_mask_off
    && paddr[1:0] == 2'h0;
  wire stat_rd = rd && paddr >= split_timer_pkg::irq_stat_off && mapped;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray pslverr");
  a_rd_zero: assert property (rd && !mapped |-> prdata == 32'h0) else $error("unmapped data");
  a_ctrl_unused: assert property (rd && paddr == split_timer_pkg::ctrl_off
    |-> prdata[4] == 1'b0 && prdata[1] == 1'b0 && prdata[31:8] == 24'h0) else $error("ctrl bits");
  a_clk_width: assert property (rd && paddr == split_timer_pkg::clk_ctl_off
    |-> prdata[31:3] == 29'h0) else $error("clk_ctl bits");
  a_stat_width: assert property (stat_rd |-> prdata[31:2] == 30'h0) else $error("stat bits");
  a_flag_sticky: assert property ($fell(timer_irq) |-> $past(acc && pwrite))
    else $error("timer_irq fell alone");
  a_stat_sticky: assert property ($fell(irq) |-> $past(acc && pwrite))
    else $error("irq fell alone");
endmodule // split_reload_timer_assertions

bind split_reload_timer split_reload_timer_assertions chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc),
  .timer_irq(timer_irq), .irq(irq));

/* sim/split_reload_timer_tb_top.sv */
`timescale 1ns/1ps
module split_reload_timer_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_osc = 1'b0, pready, pslverr, timer_irq, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'h0;
  logic [11:0] offs [8];
  int bad_count = 0, comparisons = 0;
  split_reload_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc), .timer_irq(timer_irq), .irq(irq));
  initial forever #50 pclk = ~pclk;
  // Eight pclk periods; toggles on falling pclk, so no race with sampling
  initial forever #400 ext_osc = ~ext_osc;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs settled before any compare
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask
  task automatic rate(input logic [2:0] ck, input logic [7:0] ct, input int w,
    input logic [31:0] l0, input logic [31:0] l1, input logic [31:0] h0, input logic [31:0] h1);
    wr(split_timer_pkg::clk_ctl_off, {29'h0, ck});
    wr(split_timer_pkg::ctrl_off, {24'h0, ct});
    wr(split_timer_pkg::cnt_lo_off, 32'h0);
    wr(split_timer_pkg::cnt_hi_off, 32'h0);
    repeat (w) @(posedge pclk);
    rd(split_timer_pkg::cnt_lo_off);
    rng("low count", l0, l1, q);
    rd(split_timer_pkg::cnt_hi_off);
    rng("high count", h0, h1, q);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    offs = '{split_timer_pkg::ctrl_off, split_timer_pkg::rld_lo_off, split_timer_pkg::rld_hi_off,
      split_timer_pkg::cnt_lo_off, split_timer_pkg::cnt_hi_off, split_timer_pkg::clk_ctl_off,
      split_timer_pkg::irq_stat_off, split_timer_pkg::irq_mask_off};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", 32'h0, q);
    end
    rd(12'h300);
    chk("unmapped read", 32'h1, {31'h0, err});
    wr(12'h300, 32'hFF);
    chk("unmapped write", 32'h1, {31'h0, err});
    rate(3'h3, 8'h0D, 100, 98, 110, 98, 110);
    rate(3'h0, 8'h0C, 600, 48, 53, 48, 53);
    rate(3'h0, 8'h0D, 600, 8, 12, 8, 12);
    rate(3'h3, 8'h08, 100, 98, 110, 0, 0);
    // Low byte on /12 so the flag is not set twice
    wr(split_timer_pkg::clk_ctl_off, 32'h4);
    wr(split_timer_pkg::rld_lo_off, 32'hF0);
    wr(split_timer_pkg::ctrl_off, 32'h08);
    wr(split_timer_pkg::cnt_lo_off, 32'hFF);
    repeat (60) @(posedge pclk);
    rd(split_timer_pkg::ctrl_off);
    chk("low flag", 32'h48, q);
    chk("irq no low enable", 32'h0, {31'h0, timer_irq});
    rd(split_timer_pkg::cnt_lo_off);
    rng("low reload", 32'hF0, 32'hF6, q);
    wr(split_timer_pkg::ctrl_off, 32'h68);
    chk("irq low enable", 32'h1, {31'h0, timer_irq});
    wr(split_timer_pkg::ctrl_off, 32'h28);
    chk("irq cleared", 32'h0, {31'h0, timer_irq});
    wr(split_timer_pkg::rld_hi_off, 32'hA0);
    wr(split_timer_pkg::clk_ctl_off, 32'h6);
    wr(split_timer_pkg::ctrl_off, 32'h0C);
    wr(split_timer_pkg::cnt_hi_off, 32'hFF);
    repeat (3) @(posedge pclk);
    chk("irq high", 32'h1, {31'h0, timer_irq});
    rd(split_timer_pkg::cnt_hi_off);
    rng("high reload", 32'hA0, 32'hA8, q);
    rd(split_timer_pkg::irq_stat_off);
    chk("status", 32'h3, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(split_timer_pkg::irq_mask_off, 32'h1);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(split_timer_pkg::irq_stat_off, 32'h1);
    chk("irq w1c", 32'h0, {31'h0, irq});
    rd(split_timer_pkg::irq_stat_off);
    chk("status w1c", 32'h2, q);
    wr(split_timer_pkg::ctrl_off, 32'h0);
    wr(split_timer_pkg::rld_lo_off, 32'h34);
    wr(split_timer_pkg::rld_hi_off, 32'h12);
    wr(split_timer_pkg::cnt_hi_off, 32'hFF);
    wr(split_timer_pkg::cnt_lo_off, 32'hF0);
    wr(split_timer_pkg::ctrl_off, 32'h04);
    repeat (30) @(posedge pclk);
    rd(split_timer_pkg::cnt_hi_off);
    chk("wide reload high", 32'h12, q);
    rd(split_timer_pkg::cnt_lo_off);
    rng("wide reload low", 32'h34, 32'h50, q);
    rd(split_timer_pkg::ctrl_off);
    chk("wide flag", 32'h80, q & 32'h80);
    wr(split_timer_pkg::ctrl_off, 32'h24);
    repeat (260) @(posedge pclk);
    rd(split_timer_pkg::ctrl_off);
    chk("wide low flag", 32'h40, q & 32'hC0);
    chk("wide low irq", 32'h1, {31'h0, timer_irq});
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
endmodule // split_reload_timer_tb_top
